/* include/scs_pkg.sv */
// Shared constants, types and register map of the SAR conversion sequencer
package scs_pkg;

    // ------------------------------------------------------------------
    // Clock and conversion timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_KHZ = 20_000;
    localparam int unsigned RES_BITS = 16;
    localparam int unsigned WARP_RATE_KSPS = 1000;
    localparam int unsigned NORMAL_RATE_KSPS = 800;
    localparam int unsigned IMPULSE_RATE_KSPS = 666;
    localparam int unsigned STALE_TIME_MS = 1;

    // Least period in cycles for a given rate, rounded up
    function automatic int unsigned period_cycles(input int unsigned ksps);
        return (CLK_FREQ_KHZ + ksps - 1) / ksps;
    endfunction

    // Open switches, tie to reference ground, 16 trials, finish
    localparam int unsigned CONV_CYCLES = 3 + RES_BITS;

    // Least acquisition cycles so that the period meets the rate
    function automatic int unsigned acq_cycles(input int unsigned ksps);
        int unsigned p;
        p = period_cycles(ksps);
        return (p > CONV_CYCLES + 1) ? p - CONV_CYCLES : 1;
    endfunction

    localparam int unsigned WARP_ACQ_CYCLES = acq_cycles(WARP_RATE_KSPS);
    localparam int unsigned NORMAL_ACQ_CYCLES = acq_cycles(NORMAL_RATE_KSPS);
    localparam int unsigned IMPULSE_ACQ_CYCLES =
        acq_cycles(IMPULSE_RATE_KSPS);
    localparam int unsigned STALE_CYCLES = STALE_TIME_MS * CLK_FREQ_KHZ;

    // ------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_WARP = 2'b01,
        MODE_IMPULSE = 2'b10
    } scs_mode_e;

    typedef enum logic [2:0] {
        ST_ACQUIRE = 3'b000,
        ST_OPEN_SW = 3'b001,
        ST_TO_REFERENCE_GROUND = 3'b010,
        ST_TRIAL = 3'b011,
        ST_POWER_DOWN = 3'b100
    } scs_state_e;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_RESULT = 12'h008;
    localparam logic [11:0] REG_COUNT = 12'h00c;

    localparam int unsigned CTRL_PD_BIT = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_PDOWN_BIT = 1;
    localparam int unsigned STAT_STALE_BIT = 2;
    localparam int unsigned STAT_STATE_LSB = 4;
    localparam int unsigned STAT_MODE_LSB = 8;

    localparam logic [15:0] SAR_FIRST_TRIAL = 16'h8000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Pin group order at the synchroniser
    localparam int unsigned PIN_W = 6;
    localparam logic [5:0] PIN_RESET_VAL = 6'h01;

endpackage

/* hw/scs_sync.sv */
// Two-flop synchroniser for asynchronous pins and the reset release
`timescale 1ns/1ps
module scs_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage is read only by the second stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;

endmodule

/* hw/scs_sar_core.sv */
// Successive approximation register driving the capacitive DAC
`timescale 1ns/1ps
module scs_sar_core #(
    parameter int unsigned NBITS = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort,
    input wire logic comparator_out,
    output logic [NBITS-1:0] dac_bits,
    output logic done
);
    import scs_pkg::*;

    logic [NBITS-1:0] dac_ff;
    logic [NBITS-1:0] nxt_dac;
    logic [$clog2(NBITS)-1:0] idx_ff;
    logic active_ff;
    logic done_ff;

    // Keep or drop the bit under trial, then try the next lower one
    always_comb begin
        nxt_dac = dac_ff;
        if (!comparator_out) begin
            nxt_dac[idx_ff] = 1'b0;
        end
        if (idx_ff != '0) begin
            nxt_dac[idx_ff - 1'b1] = 1'b1;
        end
    end

    // One trial per clock, MSB first, LSB last
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_ff <= '0;
            idx_ff <= '0;
            active_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (abort) begin
            dac_ff <= '0;
            idx_ff <= '0;
            active_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (start) begin
            dac_ff <= SAR_FIRST_TRIAL[NBITS-1:0];
            idx_ff <= $clog2(NBITS)'(NBITS - 1);
            active_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (active_ff) begin
            dac_ff <= nxt_dac;
            idx_ff <= idx_ff - 1'b1;
            active_ff <= (idx_ff != '0);
            done_ff <= (idx_ff == '0);
        end else begin
            done_ff <= 1'b0;
        end
    end

    assign dac_bits = dac_ff;
    assign done = done_ff;

endmodule

/* hw/scs_sequencer.sv */
// Conversion sequencer top: pins, mode timing, SAR control, APB slave
`timescale 1ns/1ps

module scs_sequencer #(
    parameter int unsigned NBITS = scs_pkg::RES_BITS,
    parameter logic [15:0] STALE_LIMIT = 16'(scs_pkg::STALE_CYCLES)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [scs_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conversion_start_n,
    input wire logic fast_mode_select,
    input wire logic low_power_select,
    input wire logic output_coding_select,
    input wire logic power_down_in,
    input wire logic reset_in,
    input wire logic comparator_out,
    output logic positive_sample_switch,
    output logic negative_sample_switch,
    output logic inputs_connect,
    output logic arrays_to_reference_ground,
    output logic [NBITS-1:0] dac_bits,
    output logic low_power_out,
    output logic busy,
    output logic [NBITS-1:0] result_code,
    output logic result_valid
);
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic rst_sync_n;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_sync;
    logic start_n_s;
    logic fast_s;
    logic lowpow_s;
    logic coding_s;
    logic pd_s;
    logic reset_s;

    scs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d_in(1'b1),
        .q_out(rst_sync_n)
    );

    assign pins_raw = {reset_in, power_down_in, output_coding_select,
                       low_power_select, fast_mode_select,
                       conversion_start_n};

    scs_sync #(.WIDTH(PIN_W), .RST_VAL(PIN_RESET_VAL)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .d_in(pins_raw),
        .q_out(pins_sync)
    );

    assign start_n_s = pins_sync[0];
    assign fast_s = pins_sync[1];
    assign lowpow_s = pins_sync[2];
    assign coding_s = pins_sync[3];
    assign pd_s = pins_sync[4];
    assign reset_s = pins_sync[5];

    // ------------------------------------------------------------------
    // Mode decode and acquisition timing
    // ------------------------------------------------------------------
    scs_mode_e mode_now;
    logic [7:0] acq_need;
    logic [7:0] acq_cnt_ff;
    logic acq_done;

    // Fast select wins; low power only with fast select low
    always_comb begin
        if (fast_s) begin
            mode_now = MODE_WARP;
        end else if (lowpow_s) begin
            mode_now = MODE_IMPULSE;
        end else begin
            mode_now = MODE_NORMAL;
        end
    end

    // Least acquisition per mode sets the top throughput
    always_comb begin
        case (mode_now)
            MODE_WARP: acq_need = 8'(WARP_ACQ_CYCLES);
            MODE_IMPULSE: acq_need = 8'(IMPULSE_ACQ_CYCLES);
            default: acq_need = 8'(NORMAL_ACQ_CYCLES);
        endcase
    end

    assign acq_done = (acq_cnt_ff >= acq_need);

    // ------------------------------------------------------------------
    // Start detection and abort sources
    // ------------------------------------------------------------------
    logic [1:0] ctrl_ff;
    logic start_n_prev_ff;
    logic start_fall;
    logic start_go;
    logic abort;
    logic pd_any;
    scs_state_e state_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            start_n_prev_ff <= 1'b1;
        end else begin
            start_n_prev_ff <= start_n_s;
        end
    end

    assign start_fall = start_n_prev_ff & ~start_n_s;
    assign abort = reset_s | ctrl_ff[CTRL_ABORT_BIT];
    assign pd_any = pd_s | ctrl_ff[CTRL_PD_BIT];

    // Early edges are lost: the host must wait for acquisition
    assign start_go = (state_ff == ST_ACQUIRE) && acq_done && !pd_any &&
        !abort && (start_fall ||
        ((mode_now == MODE_IMPULSE) && !start_n_s));

    // ------------------------------------------------------------------
    // SAR core
    // ------------------------------------------------------------------
    logic sar_start;
    logic sar_done;
    logic [NBITS-1:0] sar_bits;

    // Trials begin only once arrays sit on reference ground
    assign sar_start = (state_ff == ST_TO_REFERENCE_GROUND) && !abort;

    scs_sar_core #(.NBITS(NBITS)) u_sar (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .start(sar_start),
        .abort(abort),
        .comparator_out(comparator_out),
        .dac_bits(sar_bits),
        .done(sar_done)
    );

    assign dac_bits = sar_bits;

    // ------------------------------------------------------------------
    // Conversion state machine
    // ------------------------------------------------------------------
    scs_state_e nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_ACQUIRE: begin
                if (pd_any) begin
                    nxt_state = ST_POWER_DOWN;
                end else if (start_go) begin
                    nxt_state = ST_OPEN_SW;
                end
            end
            ST_OPEN_SW: nxt_state = ST_TO_REFERENCE_GROUND;
            ST_TO_REFERENCE_GROUND: nxt_state = ST_TRIAL;
            ST_TRIAL: begin
                // Power-down does not cut a conversion short
                if (sar_done) begin
                    nxt_state = ST_ACQUIRE;
                end
            end
            ST_POWER_DOWN: begin
                if (!pd_any) begin
                    nxt_state = ST_ACQUIRE;
                end
            end
            default: nxt_state = ST_ACQUIRE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= ST_ACQUIRE;
        end else if (abort) begin
            state_ff <= ST_ACQUIRE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Acquisition restarts whenever the sample switches close
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            acq_cnt_ff <= '0;
        end else if (abort || state_ff != ST_ACQUIRE) begin
            acq_cnt_ff <= '0;
        end else if (!acq_done) begin
            acq_cnt_ff <= acq_cnt_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Switch and power outputs, registered to avoid glitches
    // ------------------------------------------------------------------
    logic sample_sw_ff;
    logic connect_ff;
    logic reference_ground_ff;
    logic low_power_ff;
    logic busy_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sample_sw_ff <= 1'b1;
            connect_ff <= 1'b1;
            reference_ground_ff <= 1'b0;
        end else begin
            // Switches open one cycle before arrays leave inputs
            sample_sw_ff <= (nxt_state == ST_ACQUIRE) || abort;
            connect_ff <= (nxt_state == ST_ACQUIRE) ||
                (nxt_state == ST_OPEN_SW) || abort;
            reference_ground_ff <= !abort && ((nxt_state == ST_TO_REFERENCE_GROUND) ||
                (nxt_state == ST_TRIAL));
        end
    end

    // Low-power mode idles the analog between conversions
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_power_ff <= 1'b0;
        end else begin
            low_power_ff <= (state_ff == ST_POWER_DOWN) ||
                ((state_ff == ST_ACQUIRE) && acq_done &&
                (mode_now == MODE_IMPULSE));
        end
    end

    // Busy spans the whole conversion phase
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            busy_ff <= 1'b0;
        end else if (abort) begin
            busy_ff <= 1'b0;
        end else if (start_go) begin
            busy_ff <= 1'b1;
        end else if (sar_done) begin
            busy_ff <= 1'b0;
        end
    end

    assign positive_sample_switch = sample_sw_ff;
    assign negative_sample_switch = sample_sw_ff;
    assign inputs_connect = connect_ff;
    assign arrays_to_reference_ground = reference_ground_ff;
    assign low_power_out = low_power_ff;
    assign busy = busy_ff;

    // ------------------------------------------------------------------
    // Result coding and capture
    // ------------------------------------------------------------------
    logic [NBITS-1:0] result_ff;
    logic valid_ff;
    logic [15:0] count_ff;

    // Twos complement flips only the MSB of the binary code
    function automatic logic [NBITS-1:0] form_code(
        input logic [NBITS-1:0] raw,
        input logic twos
    );
        form_code = raw;
        form_code[NBITS-1] = raw[NBITS-1] ^ twos;
    endfunction

    // Code formed at the edge busy falls, no pipeline
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result_ff <= '0;
            valid_ff <= 1'b0;
            count_ff <= '0;
        end else if (abort) begin
            valid_ff <= 1'b0;
        end else if (sar_done && state_ff == ST_TRIAL) begin
            // Coding pin high selects straight binary
            result_ff <= form_code(sar_bits, !coding_s);
            valid_ff <= 1'b1;
            count_ff <= count_ff + 16'h0001;
        end else if (start_go) begin
            valid_ff <= 1'b0;
        end
    end

    assign result_code = result_ff;
    assign result_valid = valid_ff;

    // ------------------------------------------------------------------
    // Idle-time watch for the fast mode
    // ------------------------------------------------------------------
    logic [15:0] idle_cnt_ff;
    logic first_ff;
    logic stale_ff;

    // Flags a fast-mode result that the host should discard
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            idle_cnt_ff <= '0;
            first_ff <= 1'b1;
            stale_ff <= 1'b0;
        end else if (start_go) begin
            idle_cnt_ff <= '0;
            first_ff <= 1'b0;
            stale_ff <= (mode_now == MODE_WARP) &&
                (first_ff || idle_cnt_ff > STALE_LIMIT);
        end else if (idle_cnt_ff <= STALE_LIMIT) begin
            idle_cnt_ff <= idle_cnt_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // ------------------------------------------------------------------
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic wr_fire;

    always_comb begin
        rd_mux = RDATA_ZERO;
        rd_hit = 1'b1;
        case (paddr)
            REG_CTRL: rd_mux[1:0] = ctrl_ff;
            REG_STATUS: begin
                rd_mux[STAT_BUSY_BIT] = busy_ff;
                rd_mux[STAT_PDOWN_BIT] = (state_ff == ST_POWER_DOWN);
                rd_mux[STAT_STALE_BIT] = stale_ff;
                rd_mux[STAT_STATE_LSB +: 3] = state_ff;
                rd_mux[STAT_MODE_LSB +: 2] = mode_now;
            end
            REG_RESULT: rd_mux[NBITS-1:0] = result_ff;
            REG_COUNT: rd_mux[15:0] = count_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    assign wr_fire = psel && penable && pready_ff && pwrite;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready_ff <= 1'b0;
            prdata_ff <= RDATA_ZERO;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            pready_ff <= 1'b1;
            prdata_ff <= pwrite ? RDATA_ZERO : rd_mux;
            pslverr_ff <= !rd_hit;
        end else begin
            pready_ff <= 1'b0;
            prdata_ff <= RDATA_ZERO;
            pslverr_ff <= 1'b0;
        end
    end

    // Only the control word is writable
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_fire && paddr == REG_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule

/* verif/scs_monitor.sv */
// Assertion checker on the ports of the conversion sequencer
`timescale 1ns/1ps
module scs_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic power_down_in,
    input wire logic reset_in,
    input wire logic positive_sample_switch,
    input wire logic negative_sample_switch,
    input wire logic inputs_connect,
    input wire logic arrays_to_reference_ground,
    input wire logic [15:0] dac_bits,
    input wire logic busy,
    input wire logic [15:0] result_code,
    input wire logic result_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------
    // Conversion sequence
    // ----------------------------------------------
    // An abort cuts the count short
    a_busy_length: assert property (
        disable iff (!rst_n || reset_in)
        $rose(busy) |-> busy [*8] ##11 busy ##1 !busy)
        else $error("busy not high for 19 cycles");
    a_switch_order: assert property (
        $rose(busy) |-> !positive_sample_switch && !negative_sample_switch
            && inputs_connect ##1 !inputs_connect
            && arrays_to_reference_ground)
        else $error("switch order wrong at conversion start");
    a_first_trial: assert property (
        $rose(busy) |-> ##2 dac_bits == 16'h8000)
        else $error("first trial is not the top bit");
    a_last_trial: assert property (
        $rose(busy) |-> ##17 dac_bits[0])
        else $error("last trial not on the bottom bit");
    a_done_valid: assert property (
        $fell(busy) && !reset_in |-> result_valid)
        else $error("no valid result when busy fell");
    a_valid_drop: assert property (
        $rose(busy) |-> !result_valid)
        else $error("old result still valid in new conversion");
    a_result_hold: assert property (
        result_valid && $past(result_valid) && !busy |-> $stable(result_code))
        else $error("result changed outside a conversion");
    // ----------------------------------------------
    // Reset and power-down pins
    // ----------------------------------------------
    a_reset_abort: assert property (
        reset_in [*4] |-> !busy && !result_valid)
        else $error("reset input did not abort");
    a_pd_blocks: assert property (
        power_down_in [*5] ##0 !busy |=> !busy)
        else $error("conversion started in power down");
endmodule

/* verif/scs_comparator_model.sv */
// Behavioural sampled input and comparator at the far side of the arrays
`timescale 1ns/1ps
module scs_comparator_model (
    input wire logic ref_clk,
    input wire logic inputs_connect,
    input wire logic [15:0] analog_code,
    input wire logic [15:0] dac_bits,
    output logic comparator_out
);
    logic [15:0] held_ff;
    // Tracks only while the arrays sit on the inputs
    always_ff @(posedge ref_clk) begin
        if (inputs_connect) begin
            held_ff <= analog_code;
        end
    end
    // Keep the trial bit while the trial does not overshoot
    assign comparator_out = (dac_bits <= held_ff);
endmodule

/* verif/scs_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module scs_sequencer_tb_top;
    import scs_pkg::*;
    typedef struct packed {
        logic fast;
        logic lowp;
        logic bin;
        logic [15:0] code;
        logic [3:0] gap;
    } scs_row_s;
    // Gaps give acquisition time before each start
    scs_row_s rows [6] = '{
        '{1'h1, 1'h0, 1'h1, 16'h1234, 4'h1}, '{1'h1, 1'h0, 1'h0, 16'h0000, 4'h1},
        '{1'h0, 1'h0, 1'h1, 16'hffff, 4'h4}, '{1'h0, 1'h0, 1'h0, 16'h0001, 4'h4},
        '{1'h0, 1'h1, 1'h1, 16'ha5a5, 4'ha}, '{1'h0, 1'h1, 1'h0, 16'hffff, 4'ha}};
    logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, conversion_start_n = 1'h1, fast_mode_select = 1'h0;
    logic low_power_select = 1'h0, output_coding_select = 1'h1;
    logic power_down_in = 1'h0, reset_in = 1'h0, pready, pslverr;
    logic comparator_out, inputs_connect, low_power_out, busy, result_valid;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, d;
    logic [15:0] analog_code = 16'h0000, dac_bits, result_code, exp_code;
    logic e;
    int err_count = 0, n_tests = 0;
    always #25 ref_clk = ~ref_clk;
    scs_sequencer #(.STALE_LIMIT(16'h0032)) u_scs_sequencer (
        .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .conversion_start_n(conversion_start_n),
        .fast_mode_select(fast_mode_select),
        .low_power_select(low_power_select),
        .output_coding_select(output_coding_select),
        .power_down_in(power_down_in), .reset_in(reset_in),
        .comparator_out(comparator_out), .positive_sample_switch(),
        .negative_sample_switch(), .inputs_connect(inputs_connect),
        .arrays_to_reference_ground(), .dac_bits(dac_bits),
        .low_power_out(low_power_out), .busy(busy),
        .result_code(result_code), .result_valid(result_valid));
    scs_comparator_model u_scs_comparator_model (
        .ref_clk(ref_clk), .inputs_connect(inputs_connect),
        .analog_code(analog_code), .dac_bits(dac_bits),
        .comparator_out(comparator_out));
    // ----------------------------------------------
    // Shared tasks
    // ----------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, x);
        n_tests++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Bounded wait for a busy level
    task automatic wait_busy(input logic v, input int lim);
        for (int i = 0; i < lim && busy !== v; i++) @(posedge ref_clk);
        if (busy !== v) begin
            chk("busy wait", 32'(busy), 32'(v));
            summarize();
        end
    endtask
    // Start pin low for two cycles
    task automatic start;
        @(posedge ref_clk);
        conversion_start_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        conversion_start_n <= 1'h1;
    endtask
    // One APB transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        for (int i = 0; i < 8 && pready !== 1'h1; i++) @(posedge ref_clk);
        chk("pready", 32'(pready), 32'h0000_0001);
        if (pready !== 1'h1) summarize();
        d = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // ----------------------------------------------
    // Main sequence
    // ----------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (8) @(posedge ref_clk);
        // First fast result follows reset and is flagged stale; the bench still checks it
        foreach (rows[i]) begin
            fast_mode_select <= rows[i].fast;
            low_power_select <= rows[i].lowp;
            output_coding_select <= rows[i].bin;
            analog_code <= rows[i].code;
            exp_code = rows[i].bin ? rows[i].code : rows[i].code ^ 16'h8000;
            repeat (rows[i].gap) @(posedge ref_clk);
            start();
            wait_busy(1'h1, 6);
            wait_busy(1'h0, 24);
            chk("result", 32'(result_code), 32'(exp_code));
            $display("row %0d done", i);
        end
        // Mid-conversion sample change and start
        output_coding_select <= 1'h1;
        analog_code <= 16'h0f0f;
        repeat (14) @(posedge ref_clk);
        start();
        wait_busy(1'h1, 6);
        analog_code <= 16'hf0f0;
        start();
        wait_busy(1'h0, 24);
        chk("held code", 32'(result_code), 32'h0000_0f0f);
        repeat (8) @(posedge ref_clk);
        chk("busy refused", 32'(busy), 32'h0000_0000);
        $display("refusal test done");
        // Register reads and control writes
        apb(1'h0, REG_RESULT, 32'h0000_0000);
        chk("reg result", d, 32'h0000_0f0f);
        apb(1'h0, REG_COUNT, 32'h0000_0000);
        chk("reg count", d, 32'h0000_0007);
        apb(1'h0, 12'h010, 32'h0000_0000);
        chk("unmapped", {e, d[30:0]}, 32'h8000_0000);
        apb(1'h1, REG_CTRL, 32'h0000_0001);
        apb(1'h0, REG_STATUS, 32'h0000_0000);
        chk("soft pd", 32'(d[STAT_PDOWN_BIT]), 32'h0000_0001);
        apb(1'h1, REG_CTRL, 32'h0000_0000);
        $display("register test done");
        // Power-down during a conversion lets it finish
        repeat (14) @(posedge ref_clk);
        start();
        wait_busy(1'h1, 6);
        power_down_in <= 1'h1;
        wait_busy(1'h0, 24);
        chk("pd valid", 32'(result_valid), 32'h0000_0001);
        repeat (14) @(posedge ref_clk);
        start();
        repeat (8) @(posedge ref_clk);
        chk("pd blocked", 32'(busy), 32'h0000_0000);
        chk("pd power", 32'(low_power_out), 32'h0000_0001);
        power_down_in <= 1'h0;
        $display("power-down test done");
        // Reset input mid-conversion
        repeat (14) @(posedge ref_clk);
        start();
        wait_busy(1'h1, 6);
        reset_in <= 1'h1;
        repeat (5) @(posedge ref_clk);
        chk("abort busy", 32'(busy), 32'h0000_0000);
        chk("abort valid", 32'(result_valid), 32'h0000_0000);
        reset_in <= 1'h0;
        $display("reset test done");
        summarize();
    end
    // Overall limit against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        summarize();
    end
endmodule
bind scs_sequencer scs_monitor u_scs_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .power_down_in(power_down_in),
    .reset_in(reset_in), .positive_sample_switch(positive_sample_switch),
    .negative_sample_switch(negative_sample_switch),
    .inputs_connect(inputs_connect),
    .arrays_to_reference_ground(arrays_to_reference_ground),
    .dac_bits(dac_bits), .busy(busy), .result_code(result_code),
    .result_valid(result_valid));
